// File: hw/hsdet_defs.vh
// Offsets, field positions, reset values and timing counts for the headset detect and ADC gain registers
`ifndef HSDET_DEFS_VH
`define HSDET_DEFS_VH

// Register offsets
`define OFS_DETECT_CTRL       8'h0D
`define OFS_STATUS_DRV        8'h0E
`define OFS_LEFT_GAIN         8'h0F
`define OFS_RIGHT_GAIN        8'h10

// Detect control fields
`define BIT_DET_EN            7
`define FLD_TYPE_HI           6
`define FLD_TYPE_LO           5
`define FLD_JDB_HI            4
`define FLD_JDB_LO            2
`define FLD_BDB_HI            1
`define FLD_BDB_LO            0

// Status and driver fields
`define BIT_AC_COUPLED        7
`define BIT_FULL_DIFF         6
`define BIT_BTN_FLAG          5
`define BIT_HS_FLAG           4
`define BIT_PSEUDO_DIFF       3

// Gain fields
`define BIT_MUTE              7
`define GAIN_MAX_CODE         7'h77

// Reset values
`define RST_DETECT_CTRL       8'h00
`define RST_STATUS_DRV        8'h00
`define RST_GAIN_MUTE         8'h80

// Timing: base tick in microseconds and clock rate in kHz
`define TICK_BASE_US          1000
`define CLK_KHZ               10000
`define TICK_BASE_CYCLES      ((`TICK_BASE_US * `CLK_KHZ) / 1000)
`define DEBOUNCE_SAMPLES      8

`endif

// File: hw/debounce_tick.v
// Base tick generator: one pulse per base period
`timescale 1ns/10ps
module debounce_tick #(
    parameter CYCLES = 10000
) (
    // Clock and reset
    input wire        ref_clk,
    input wire        resetn,
    // Tick output
    output reg        tick_q
);
    reg [23:0] cnt_q;

    always @(posedge ref_clk) begin
        if (!resetn) begin
            cnt_q  <= 24'h000000;
            tick_q <= 1'b0;
        end else if (cnt_q == CYCLES[23:0] - 24'h000001) begin
            cnt_q  <= 24'h000000;
            tick_q <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 24'h000001;
            tick_q <= 1'b0;
        end
    end
endmodule

// File: hw/sample_filter.v
// Debounce filter: output follows input after it holds steady for a full count of sample ticks
`timescale 1ns/10ps
module sample_filter #(
    parameter W = 2
) (
    // Clock and reset
    input wire          ref_clk,
    input wire          resetn,
    // Control
    input wire          enable,
    input wire          bypass,
    input wire          sample,
    input wire [3:0]    samples,
    // Data
    input wire [W-1:0]  din,
    output reg [W-1:0]  dout_q
);
    reg [W-1:0] last_q;
    reg [3:0]   cnt_q;

    always @(posedge ref_clk) begin
        if (!resetn || !enable) begin
            last_q <= {W{1'b0}};
            cnt_q  <= 4'h0;
            dout_q <= {W{1'b0}};
        end else if (bypass) begin
            last_q <= din;
            cnt_q  <= 4'h0;
            dout_q <= din;
        end else if (sample) begin
            if (din != last_q) begin
                last_q <= din;
                cnt_q  <= 4'h1;
            end else if (cnt_q >= samples) begin
                dout_q <= last_q;
            end else begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule

// File: hw/headset_detect_and_adc_gain_regs.v
// Headset detection, button detection and ADC input amplifier gain/mute registers
// Overview of operation
// (RQ1) Detection runs only while the enable bit is set; it resets clear.
// (RQ2) Read-only two-bit field reports none, stereo, cellular or both.
// (RQ3) Jack debounce 16 to 512 ms by code 0-5, sampled at one eighth.
// (RQ4) Software never writes jack debounce codes 110 or 111.
// (RQ5) Button debounce none, 8, 16 or 32 ms, sampled at 1, 2, 4 ms.
// (RQ6) Coupling bit selects capless when clear, AC-coupled when set.
// (RQ7) Bit set means stereo outputs fully differential; resets clear.
// (RQ8) Bit set means stereo outputs pseudo-differential; resets clear.
// (RQ9) Software never sets both differential configuration bits together.
// (RQ10) Sticky button flag set on debounced press, cleared by reading it.
// (RQ11) Headset flag reads one while a headset is detected; resets zero.
// (RQ12) Software writes only zeros to the three reserved low bits.
// (RQ13) Left amplifier mute bit mutes when set, resets to one.
// (RQ14) Right amplifier mute bit mutes when set, resets to one.
// (RQ15) Seven-bit gain per channel, 0.5 dB per step from zero, resets zero.
// (RQ16) Gain codes 1110111 and above give the 59.5 dB maximum.
// (RQ17) Type and flags change only after input holds for the whole interval.
// (RQ18) Status writes ignored; press in the clearing read cycle stays flagged.
`timescale 1ns/10ps
`include "hsdet_defs.vh"
module headset_detect_and_adc_gain_regs #(
    parameter TICK_CYCLES = `TICK_BASE_CYCLES
) (
    // Clock and reset
    input wire        ref_clk,
    input wire        resetn,
    // Register access
    input wire [7:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    output reg [7:0]  reg_rdata_q,
    // Jack sense pins
    input wire        jack_stereo,
    input wire        jack_cellular,
    input wire        jack_button,
    // Analog configuration outputs
    output reg        ac_coupled_q,
    output reg        full_diff_q,
    output reg        pseudo_diff_q,
    output reg        left_mute_q,
    output reg [6:0]  left_gain_q,
    output reg        right_mute_q,
    output reg [6:0]  right_gain_q
);
    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function [6:0] clamp_gain;
        input [6:0] code;
        begin
            clamp_gain = (code > `GAIN_MAX_CODE) ? `GAIN_MAX_CODE : code; // RQ16
        end
    endfunction

    // Mute bit above the seven-bit gain code, as both gain registers read back
    function [7:0] gain_view;
        input       mute;
        input [6:0] code;
        begin
            gain_view = {mute, code};
        end
    endfunction

    // True when the divider count is a multiple of two to the power shift
    function tick_due;
        input [5:0] div;
        input [2:0] shift;
        begin
            case (shift)
                3'h0: tick_due = 1'b1;
                3'h1: tick_due = (div[0] == 1'b0);
                3'h2: tick_due = (div[1:0] == 2'h0);
                3'h3: tick_due = (div[2:0] == 3'h0);
                3'h4: tick_due = (div[3:0] == 4'h0);
                3'h5: tick_due = (div[4:0] == 5'h00);
                default: tick_due = (div == 6'h00);
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    reg        det_en_q;
    reg [2:0]  jack_db_q;
    reg [1:0]  btn_db_q;
    reg        btn_flag_q;
    reg [6:0]  lgain_code_q;
    reg [6:0]  rgain_code_q;

    // Pin synchronisers
    reg [2:0]  sync1_q;
    reg [2:0]  sync2_q;

    always @(posedge ref_clk) begin
        if (!resetn) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end else begin
            sync1_q <= {jack_button, jack_cellular, jack_stereo};
            sync2_q <= sync1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sample tick dividers

    wire       base_tick;
    reg [5:0]  div_q;
    reg        base_d1_q;

    debounce_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .tick_q  (base_tick)
    );

    // Counts base ticks; the delayed tick lets the selectors see the updated count
    always @(posedge ref_clk) begin
        if (!resetn) begin
            div_q     <= 6'h00;
            base_d1_q <= 1'b0;
        end else begin
            base_d1_q <= base_tick;
            if (base_tick)
                div_q <= div_q + 6'h01;
        end
    end

    // Jack sample period 2 ms << code; button 1 ms << (code-1)
    reg [2:0]  jack_shift;
    reg [2:0]  btn_shift;
    reg        jack_sample;
    reg        btn_sample;

    always @* begin
        case (jack_db_q) // RQ3
            3'h0: jack_shift = 3'h1;
            3'h1: jack_shift = 3'h2;
            3'h2: jack_shift = 3'h3;
            3'h3: jack_shift = 3'h4;
            3'h4: jack_shift = 3'h5;
            // Reserved codes fall back to the slowest tick
            default: jack_shift = 3'h6;
        endcase
        case (btn_db_q) // RQ5
            2'h1: btn_shift = 3'h0;
            2'h2: btn_shift = 3'h1;
            default: btn_shift = 3'h2;
        endcase
        // Both selectors share one divider so their sample points stay aligned
        jack_sample = base_d1_q && tick_due(div_q, jack_shift);
        btn_sample  = base_d1_q && tick_due(div_q, btn_shift);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Debounce filters

    wire [1:0] hs_type;
    wire       btn_level;
    reg        btn_prev_q;

    sample_filter #(
        .W (2)
    ) u_jack (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .enable  (det_en_q), // RQ1
        .bypass  (1'b0),
        .sample  (jack_sample),
        .samples (4'h8), // RQ17
        .din     (sync2_q[1:0]),
        .dout_q  (hs_type)
    );

    sample_filter #(
        .W (1)
    ) u_btn (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .enable  (det_en_q),
        .bypass  (btn_db_q == 2'h0), // RQ5
        .sample  (btn_sample),
        .samples (4'h8), // RQ17
        .din     (sync2_q[2]),
        .dout_q  (btn_level)
    );

    wire hs_present = (hs_type != 2'h0); // RQ11
    // A press only counts while a headset is seated
    wire btn_press  = btn_level && !btn_prev_q && hs_present;
    wire status_rd  = reg_rd && (reg_addr == `OFS_STATUS_DRV);

    ////////////////////////////////////////////////////////////////////////////////
    // Register writes

    always @(posedge ref_clk) begin
        if (!resetn) begin
            det_en_q      <= 1'b0; // RQ1
            jack_db_q     <= 3'h0;
            btn_db_q      <= 2'h0;
            ac_coupled_q  <= 1'b0; // RQ6
            full_diff_q   <= 1'b0; // RQ7
            pseudo_diff_q <= 1'b0; // RQ8
            left_mute_q   <= 1'b1; // RQ13
            right_mute_q  <= 1'b1; // RQ14
            lgain_code_q  <= 7'h00; // RQ15
            rgain_code_q  <= 7'h00;
        end else begin
            if (reg_wr) begin
                case (reg_addr)
                    // Type bits of this register are status and take no write
                    `OFS_DETECT_CTRL: begin
                        det_en_q  <= reg_wdata[`BIT_DET_EN];
                        jack_db_q <= reg_wdata[`FLD_JDB_HI:`FLD_JDB_LO];
                        btn_db_q  <= reg_wdata[`FLD_BDB_HI:`FLD_BDB_LO];
                    end
                    `OFS_STATUS_DRV: begin
                        // Read-only flag bits are not touched
                        ac_coupled_q  <= reg_wdata[`BIT_AC_COUPLED]; // RQ6 RQ18
                        full_diff_q   <= reg_wdata[`BIT_FULL_DIFF]; // RQ7
                        pseudo_diff_q <= reg_wdata[`BIT_PSEUDO_DIFF]; // RQ8
                    end
                    `OFS_LEFT_GAIN: begin
                        left_mute_q  <= reg_wdata[`BIT_MUTE]; // RQ13
                        lgain_code_q <= reg_wdata[6:0];
                    end
                    `OFS_RIGHT_GAIN: begin
                        right_mute_q <= reg_wdata[`BIT_MUTE]; // RQ14
                        rgain_code_q <= reg_wdata[6:0];
                    end
                    // Unmapped offsets change nothing
                    default: begin
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky button flag

    // A debounced rising edge sets the flag; reading the status register clears it
    always @(posedge ref_clk) begin
        if (!resetn) begin
            btn_flag_q <= 1'b0;
            btn_prev_q <= 1'b0;
        end else begin
            btn_prev_q <= btn_level;
            // Set wins over the clearing read, so a press in that cycle shows on the next read
            if (btn_press)
                btn_flag_q <= 1'b1; // RQ10 RQ18
            else if (status_rd)
                btn_flag_q <= 1'b0; // RQ10
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Effective amplifier gain

    // Codes above the top step hold the maximum; registered so the outputs come from flops
    always @(posedge ref_clk) begin
        if (!resetn) begin
            left_gain_q  <= 7'h00;
            right_gain_q <= 7'h00;
        end else begin
            left_gain_q  <= clamp_gain(lgain_code_q); // RQ15 RQ16
            right_gain_q <= clamp_gain(rgain_code_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read data

    wire [7:0] ctrl_view   = {det_en_q, hs_type, jack_db_q, btn_db_q}; // RQ2
    wire [7:0] status_view = {ac_coupled_q, full_diff_q, btn_flag_q, hs_present, pseudo_diff_q, 3'h0}; // RQ11

    reg  [7:0] rdata_d;

    always @* begin
        case (reg_addr)
            `OFS_DETECT_CTRL: rdata_d = ctrl_view; // RQ2
            `OFS_STATUS_DRV:  rdata_d = status_view; // RQ11
            `OFS_LEFT_GAIN:   rdata_d = gain_view(left_mute_q, lgain_code_q); // RQ13
            `OFS_RIGHT_GAIN:  rdata_d = gain_view(right_mute_q, rgain_code_q); // RQ14
            default:          rdata_d = 8'h00;
        endcase
    end

    always @(posedge ref_clk) begin
        if (!resetn)
            reg_rdata_q <= 8'h00;
        else if (reg_rd)
            reg_rdata_q <= rdata_d;
    end
endmodule

// File: tb/jack_model.sv
// Accessory jack model: plug and button contacts with mechanical bounce
`timescale 1ns/10ps
module jack_model #(
    parameter BOUNCE = 6
) (
    // Clock
    input wire        ref_clk,
    // Accessory state
    input wire [1:0]  plug,
    input wire        press,
    // Contact pins
    output logic      jack_stereo,
    output logic      jack_cellular,
    output logic      jack_button
);
    logic [2:0] last_q = 3'h0;
    int         bounce_q = 0;
    wire  [2:0] now = {press && plug != 2'h0, plug};
    // Contacts chatter after every change; the button closes only with a plug in
    always @(posedge ref_clk) begin
        if (now != last_q) bounce_q <= BOUNCE;
        else if (bounce_q != 0) bounce_q <= bounce_q - 1;
        last_q <= now;
    end
    assign {jack_button, jack_cellular, jack_stereo} = (bounce_q[0]) ? ~last_q : last_q;
endmodule

// File: tb/hsdet_checker.sv
// Concurrent checks on the headset detect and ADC gain register ports
`timescale 1ns/10ps
`include "hsdet_defs.vh"
module hsdet_checker (
    // Clock and reset
    input wire        ref_clk,
    input wire        resetn,
    // Register access
    input wire [7:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata_q,
    // Analog configuration
    input wire        ac_coupled_q,
    input wire        full_diff_q,
    input wire        pseudo_diff_q,
    input wire        left_mute_q,
    input wire [6:0]  left_gain_q,
    input wire        right_mute_q,
    input wire [6:0]  right_gain_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    function automatic [6:0] clamp(input [6:0] c);
        clamp = (c > 7'h77) ? 7'h77 : c;
    endfunction
    sequence s_wr(a);
        reg_wr && reg_addr == a;
    endsequence
    // Mute lands one cycle after the write, clamped gain one cycle later
    sequence s_left_apply;
        ##1 left_mute_q == $past(reg_wdata[7]) ##1 left_gain_q == clamp($past(reg_wdata[6:0], 2));
    endsequence
    sequence s_right_apply;
        ##1 right_mute_q == $past(reg_wdata[7]) ##1 right_gain_q == clamp($past(reg_wdata[6:0], 2));
    endsequence
    property p_coupling;
        s_wr(`OFS_STATUS_DRV) |=> ac_coupled_q == $past(reg_wdata[7]);
    endproperty
    property p_full_diff;
        s_wr(`OFS_STATUS_DRV) |=> full_diff_q == $past(reg_wdata[6]);
    endproperty
    property p_pseudo_diff;
        s_wr(`OFS_STATUS_DRV) |=> pseudo_diff_q == $past(reg_wdata[3]);
    endproperty
    property p_left_gain;
        s_wr(`OFS_LEFT_GAIN) |-> s_left_apply;
    endproperty
    property p_right_gain;
        s_wr(`OFS_RIGHT_GAIN) |-> s_right_apply;
    endproperty
    property p_gain_cap;
        left_gain_q <= 7'h77 && right_gain_q <= 7'h77;
    endproperty
    property p_reserved_rd;
        reg_rd && reg_addr == `OFS_STATUS_DRV |=> reg_rdata_q[2:0] == 3'h0;
    endproperty
    property p_rdata_hold;
        !reg_rd |=> $stable(reg_rdata_q);
    endproperty
    property p_reset_vals;
        $rose(resetn) |-> left_mute_q && right_mute_q && left_gain_q == 7'h00 && right_gain_q == 7'h00
            && !ac_coupled_q && !full_diff_q && !pseudo_diff_q;
    endproperty
    a_coupling: assert property (p_coupling) else $error("coupling bit not taken from write");
    a_full_diff: assert property (p_full_diff) else $error("full diff bit not taken");
    a_pseudo_diff: assert property (p_pseudo_diff) else $error("pseudo diff bit not taken");
    a_left_gain: assert property (p_left_gain) else $error("left mute or gain wrong");
    a_right_gain: assert property (p_right_gain) else $error("right mute or gain wrong");
    a_gain_cap: assert property (p_gain_cap) else $error("gain above maximum");
    a_reserved_rd: assert property (p_reserved_rd) else $error("reserved bits not zero");
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");
    a_reset_vals: assert property (p_reset_vals) else $error("wrong value after reset");
endmodule
bind headset_detect_and_adc_gain_regs hsdet_checker chk_u (.ref_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_q, .ac_coupled_q, .full_diff_q, .pseudo_diff_q, .left_mute_q, .left_gain_q,
    .right_mute_q, .right_gain_q);

// File: tb/headset_detect_and_adc_gain_regs_tb.sv
// Self-checking bench for the headset detect and ADC gain register block
`timescale 1ns/10ps
`define CHECK(w, e, g) begin compares++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value %s expected %h seen %h", w, e, g); end end
module headset_detect_and_adc_gain_regs_tb;
    localparam TICK = 10;
    logic ref_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, press = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd_val;
    logic [1:0] plug = 2'h0;
    wire jack_stereo, jack_cellular, jack_button, ac_coupled_q, full_diff_q, pseudo_diff_q, left_mute_q, right_mute_q;
    wire [7:0] reg_rdata_q;
    wire [6:0] left_gain_q, right_gain_q;
    int mismatches = 0, compares = 0;
    logic [31:0] rows [13] = '{32'h0D979700, 32'h0D000000, 32'h0E808080, 32'h0E404040, 32'h0E080808,
        32'h0E300000, 32'h0F767676, 32'h0F787877, 32'h0F7F7F77, 32'h0F000000, 32'h10F7F7F7, 32'h10010101,
        32'h11FF0000};
    logic [7:0] rst_val [4] = '{8'h00, 8'h00, 8'h80, 8'h80};
    logic [4:0] kinds [4] = '{5'h0C, 5'h19, 5'h12, 5'h00};
    headset_detect_and_adc_gain_regs #(.TICK_CYCLES(TICK)) dut_u (.ref_clk(ref_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
        .jack_stereo(jack_stereo), .jack_cellular(jack_cellular), .jack_button(jack_button),
        .ac_coupled_q(ac_coupled_q), .full_diff_q(full_diff_q), .pseudo_diff_q(pseudo_diff_q),
        .left_mute_q(left_mute_q), .left_gain_q(left_gain_q), .right_mute_q(right_mute_q),
        .right_gain_q(right_gain_q));
    jack_model jack_u (.ref_clk(ref_clk), .plug(plug), .press(press), .jack_stereo(jack_stereo),
        .jack_cellular(jack_cellular), .jack_button(jack_button));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    function automatic [7:0] port_view(input [7:0] a);
        case (a)
            8'h0E: port_view = {ac_coupled_q, full_diff_q, 2'h0, pseudo_diff_q, 3'h0};
            8'h0F: port_view = {left_mute_q, left_gain_q};
            8'h10: port_view = {right_mute_q, right_gain_q};
            default: port_view = 8'h00;
        endcase
    endfunction
    task finish_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata_q;
    endtask
    // Polls a field, then checks it did not settle before min_cyc cycles; callers pass seven debounce sample periods
    task wait_rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input int min_cyc);
        int n;
        n = 0;
        rd(a);
        while ((rd_val & m) !== e && n < 4000) begin
            rd(a);
            n += 2;
        end
        `CHECK("polled field", e, rd_val & m)
        `CHECK("settle time", 1'b1, n >= min_cyc)
        if (n >= 4000) finish_test();
    endtask
    initial begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        #1 `CHECK("mutes", 2'h3, {left_mute_q, right_mute_q})
        `CHECK("gains", 14'h0000, {left_gain_q, right_gain_q})
        for (int i = 0; i < 4; i++) begin
            rd(8'h0D + i);
            `CHECK("reset value", rst_val[i], rd_val)
        end
        foreach (rows[i]) begin
            wr(rows[i][31:24], rows[i][23:16]);
            rd(rows[i][31:24]);
            `CHECK("readback", rows[i][15:8], rd_val)
            `CHECK("port view", rows[i][7:0], port_view(rows[i][31:24]))
        end
        plug <= 2'h1;
        repeat (300) @(posedge ref_clk);
        rd(8'h0E);
        `CHECK("flag while off", 8'h00, rd_val & 8'h10)
        foreach (kinds[i]) begin
            wr(8'h0D, {1'b1, 2'h0, kinds[i][2:0], 2'h1});
            plug <= kinds[i][4:3];
            wait_rd(8'h0D, 8'h60, {1'b0, kinds[i][4:3], 5'h00}, 7 * (2 * TICK << kinds[i][2:0]));
            rd(8'h0E);
            `CHECK("headset flag", kinds[i][4:3] != 2'h0, rd_val[4])
        end
        plug <= 2'h1;
        wait_rd(8'h0E, 8'h10, 8'h10, 7 * 2 * TICK);
        press <= 1'b1;
        wait_rd(8'h0E, 8'h20, 8'h20, 7 * TICK);
        press <= 1'b0;
        rd(8'h0E);
        `CHECK("flag after read", 1'b0, rd_val[5])
        wr(8'h0D, 8'h80);
        press <= 1'b1;
        repeat (6) @(posedge ref_clk);
        press <= 1'b0;
        repeat (4) @(posedge ref_clk);
        rd(8'h0E);
        `CHECK("undebounced press", 1'b1, rd_val[5])
        wr(8'h0D, 8'h00);
        rd(8'h0E);
        `CHECK("flag after disable", 1'b0, rd_val[4])
        wr(8'h0F, 8'h05);
        wr(8'h0E, 8'h80);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        #1 `CHECK("left after reset", 8'h80, port_view(8'h0F))
        rd(8'h0E);
        `CHECK("status after reset", 8'h00, rd_val)
        finish_test();
    end
endmodule
